// file: logic/asp_map.svh
// register offsets, field positions and frame timing of the serial port unit
// assumes an 8-bit register port with a 3-bit offset
`ifndef ASP_MAP_SVH
`define ASP_MAP_SVH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define ASP_OFS_DATA 3'h0
`define ASP_OFS_IEN 3'h1
`define ASP_OFS_IID 3'h2
`define ASP_OFS_LCTL 3'h3
`define ASP_OFS_MCTL 3'h4
`define ASP_OFS_LSTAT 3'h5
`define ASP_OFS_MSTAT 3'h6
`define ASP_OFS_SCR 3'h7

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define ASP_LCR_STOP 2
`define ASP_LCR_PAR_ON 3
`define ASP_LCR_EVEN 4
`define ASP_LCR_STICK 5
`define ASP_LCR_BREAK 6
`define ASP_LCR_DIV_ACCESS 7
`define ASP_MCR_LOOP 4

// ------------------------------------------------------------
// identification codes and timing in sixteenths of a bit
// ------------------------------------------------------------
`define ASP_ID_LINE 2'h3
`define ASP_ID_RXDATA 2'h2
`define ASP_ID_TXEMPTY 2'h1
`define ASP_ID_MODEM 2'h0
`define ASP_PH_MID 5'h07
`define ASP_PH_BIT_END 5'h0f
`define ASP_PH_STOP1 5'h0f
`define ASP_PH_STOP15 5'h17
`define ASP_PH_STOP2 5'h1f

`endif

// file: logic/asp_pkg.sv
// types shared by the serial port unit
// assumes nothing of its surroundings
package asp_pkg;

    // frame position, used by both the sender and the receiver
    typedef enum logic [4:0]
    {
        ST_IDLE = 5'h01,
        ST_START = 5'h02,
        ST_DATA = 5'h04,
        ST_PAR = 5'h08,
        ST_STOP = 5'h10
    } asp_frame_t;

endpackage

// file: logic/asp_serial_port.sv
// serial port unit: register port, baud generator, sender, receiver, modem lines
// assumes a host on the same clock giving one-cycle rd_en / wr_en pulses
`timescale 1ns/1ps
`include "asp_map.svh"

// What this block does
// - frame: start, data, optional parity, stop
// - stop select: 1, 1.5 for 5-bit, else 2
// - divisor 1..65535 gives sixteen-times bit tick
// - receiver samples on the same tick
// - offset 0 data, offset 1 enables when clear
// - offsets 2..7 fixed, independent of access bit
// - access bit set: offsets 0,1 are divisor bytes
// - receive buffer read-only, holding register write-only
// - enable bits 0..3 per source, 4..7 zero
// - identification: bit0 low when pending, code, zeros
// - length bits give five to eight data bits
// - stop select, parity on, even, stick parity
// - break forces line low outside loopback; bit7 divisor access
// - modem control drives outputs and loopback
// - line status flags, bit7 reads zero
// - holding empty and both-empty flags
// - modem status change bits
// - modem status present levels
module asp_serial_port
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [2:0] addr,
    input wire logic rd_en,
    input wire logic wr_en,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata,
    output logic irq,
    input wire logic sin,
    output logic sout,
    input wire logic cts_n,
    input wire logic dsr_n,
    input wire logic ri_n,
    input wire logic dcd_n,
    output logic dtr_n,
    output logic rts_n,
    output logic out1_n,
    output logic out2_n
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    // pin levels are kept active high: 1 means line low / signal asserted
    typedef struct packed
    {
        logic [7:0] receive_buffer;
        logic [7:0] transmit_holding;
        logic thr_full;
        logic [3:0] interrupt_enable;
        logic [7:0] line_control;
        logic [4:0] modem_control;
        logic [7:0] scr;
        logic [15:0] div;
        logic dr;
        logic oe;
        logic pe;
        logic fe;
        logic bi;
        logic tx_holding_empty_irq;
        logic [3:0] delta;
        logic [3:0] mprev;
        logic [4:0] sync1;
        logic [4:0] sync2;
        logic [15:0] bcnt;
        asp_pkg::asp_frame_t tx_st;
        logic [7:0] tx_sh;
        logic [4:0] tx_ph;
        logic [2:0] tx_bit;
        logic tx_par;
        logic tx_space;
        asp_pkg::asp_frame_t rx_st;
        logic [7:0] rx_sh;
        logic [4:0] rx_ph;
        logic [2:0] rx_bit;
        logic rx_par;
        logic [7:0] rdata;
    } asp_state_t;

    localparam asp_state_t RST_ST = '{tx_st: asp_pkg::ST_IDLE, rx_st: asp_pkg::ST_IDLE, default: '0};

    asp_state_t st_ff;
    asp_state_t nxt_st;

    logic tick;
    logic loop;
    logic [2:0] nbits;
    logic [4:0] stop_end;
    logic rx_line;
    logic [3:0] mlvl;
    logic [7:0] rx_data;
    logic rx_done;
    logic [7:0] interrupt_identification;
    logic [7:0] line_status;
    logic [7:0] modem_status;
    logic [3:0] pend;
    logic div_acc;
    logic thr_wr;

    // parity bit for the given data and line settings
    function automatic logic par_bit(input logic [7:0] d, input logic [2:0] n, input logic [7:0] lc);
        logic [7:0] m;
        m = d & (8'hff >> (3'h7 - n));
        if (lc[`ASP_LCR_STICK])
            par_bit = ~lc[`ASP_LCR_EVEN];
        else
            par_bit = lc[`ASP_LCR_EVEN] ? ^m : ~^m;
    endfunction

    // ------------------------------------------------------------
    // decode of settings and status views
    // ------------------------------------------------------------
    assign loop = st_ff.modem_control[`ASP_MCR_LOOP];
    assign div_acc = st_ff.line_control[`ASP_LCR_DIV_ACCESS];
    assign thr_wr = wr_en && (addr == `ASP_OFS_DATA) && !div_acc;
    assign nbits = 3'h4 + {1'b0, st_ff.line_control[1:0]};
    // 1.5 stop bits only in five-bit mode
    assign stop_end = !st_ff.line_control[`ASP_LCR_STOP] ? `ASP_PH_STOP1 :
                      (st_ff.line_control[1:0] == 2'h0) ? `ASP_PH_STOP15 : `ASP_PH_STOP2;
    // baud tick when the down counter wraps; divisor 0 acts as 1
    assign tick = (st_ff.bcnt == 16'h0000);
    // loopback feeds the sender back and the control bits to the modem inputs
    assign rx_line = loop ? st_ff.tx_space : st_ff.sync2[0];
    assign mlvl = loop ? {st_ff.modem_control[3], st_ff.modem_control[2], st_ff.modem_control[0], st_ff.modem_control[1]} : st_ff.sync2[4:1];
    assign rx_data = st_ff.rx_sh >> (3'h7 - nbits);
    assign rx_done = (st_ff.rx_st == asp_pkg::ST_STOP) && tick && (st_ff.rx_ph == `ASP_PH_MID);

    assign line_status = {1'b0, (st_ff.tx_st == asp_pkg::ST_IDLE) && !st_ff.thr_full, !st_ff.thr_full,
                  st_ff.bi, st_ff.fe, st_ff.pe, st_ff.oe, st_ff.dr};
    assign modem_status = {mlvl, st_ff.delta};

    // sources in priority order: line, data, holding empty, modem
    assign pend[3] = st_ff.interrupt_enable[2] && (st_ff.oe || st_ff.pe || st_ff.fe || st_ff.bi);
    assign pend[2] = st_ff.interrupt_enable[0] && st_ff.dr;
    assign pend[1] = st_ff.interrupt_enable[1] && st_ff.tx_holding_empty_irq;
    assign pend[0] = st_ff.interrupt_enable[3] && (st_ff.delta != 4'h0);

    always_comb
    begin
        interrupt_identification = 8'h01;
        if (pend[3])
            interrupt_identification = {5'h00, `ASP_ID_LINE, 1'b0};
        else if (pend[2])
            interrupt_identification = {5'h00, `ASP_ID_RXDATA, 1'b0};
        else if (pend[1])
            interrupt_identification = {5'h00, `ASP_ID_TXEMPTY, 1'b0};
        else if (pend[0])
            interrupt_identification = {5'h00, `ASP_ID_MODEM, 1'b0};
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_st = st_ff;

        // two-stage synchronisers, stored active high
        nxt_st.sync1 = {~dcd_n, ~ri_n, ~dsr_n, ~cts_n, ~sin};
        nxt_st.sync2 = st_ff.sync1;

        // baud generator
        nxt_st.bcnt = tick ? ((st_ff.div == 16'h0000) ? 16'h0000 : st_ff.div - 16'h0001)
                           : st_ff.bcnt - 16'h0001;

        // register reads with their side effects; set below wins over clear
        if (rd_en)
        begin
            case (addr)
                `ASP_OFS_DATA:
                begin
                    nxt_st.rdata = div_acc ? st_ff.div[7:0] : st_ff.receive_buffer;
                    if (!div_acc)
                        nxt_st.dr = 1'b0;
                end
                `ASP_OFS_IEN:
                    nxt_st.rdata = div_acc ? st_ff.div[15:8] : {4'h0, st_ff.interrupt_enable};
                `ASP_OFS_IID:
                begin
                    nxt_st.rdata = interrupt_identification;
                    if (interrupt_identification[2:0] == {`ASP_ID_TXEMPTY, 1'b0})
                        nxt_st.tx_holding_empty_irq = 1'b0;
                end
                `ASP_OFS_LCTL:
                    nxt_st.rdata = st_ff.line_control;
                `ASP_OFS_MCTL:
                    nxt_st.rdata = {3'h0, st_ff.modem_control};
                `ASP_OFS_LSTAT:
                begin
                    nxt_st.rdata = line_status;
                    nxt_st.oe = 1'b0;
                    nxt_st.pe = 1'b0;
                    nxt_st.fe = 1'b0;
                    nxt_st.bi = 1'b0;
                end
                `ASP_OFS_MSTAT:
                begin
                    nxt_st.rdata = modem_status;
                    nxt_st.delta = 4'h0;
                end
                default:
                    nxt_st.rdata = st_ff.scr;
            endcase
        end

        // register writes; holding register cannot be read back
        if (wr_en)
        begin
            case (addr)
                `ASP_OFS_DATA:
                    if (div_acc)
                        nxt_st.div[7:0] = wdata;
                    else
                    begin
                        nxt_st.transmit_holding = wdata;
                        nxt_st.thr_full = 1'b1;
                        nxt_st.tx_holding_empty_irq = 1'b0;
                    end
                `ASP_OFS_IEN:
                    if (div_acc)
                        nxt_st.div[15:8] = wdata;
                    else
                        nxt_st.interrupt_enable = wdata[3:0];
                `ASP_OFS_LCTL:
                    nxt_st.line_control = wdata;
                `ASP_OFS_MCTL:
                    nxt_st.modem_control = wdata[4:0];
                `ASP_OFS_SCR:
                    nxt_st.scr = wdata;
                default:
                    nxt_st.scr = st_ff.scr;
            endcase
        end

        // modem change detection; ring counts only its trailing edge
        nxt_st.mprev = mlvl;
        nxt_st.delta[0] = nxt_st.delta[0] | (mlvl[0] ^ st_ff.mprev[0]);
        nxt_st.delta[1] = nxt_st.delta[1] | (mlvl[1] ^ st_ff.mprev[1]);
        nxt_st.delta[2] = nxt_st.delta[2] | (st_ff.mprev[2] & ~mlvl[2]);
        nxt_st.delta[3] = nxt_st.delta[3] | (mlvl[3] ^ st_ff.mprev[3]);

        // sender, advancing one sixteenth per tick
        if (tick)
        begin
            nxt_st.tx_ph = st_ff.tx_ph + 5'h01;
            case (st_ff.tx_st)
                asp_pkg::ST_IDLE:
                begin
                    nxt_st.tx_ph = 5'h00;
                    if (st_ff.thr_full)
                    begin
                        nxt_st.tx_sh = st_ff.transmit_holding;
                        nxt_st.tx_par = par_bit(st_ff.transmit_holding, nbits, st_ff.line_control);
                        // a same-cycle write keeps the holding register full
                        nxt_st.thr_full = thr_wr;
                        nxt_st.tx_holding_empty_irq = !thr_wr;
                        nxt_st.tx_space = 1'b1;
                        nxt_st.tx_st = asp_pkg::ST_START;
                    end
                end
                asp_pkg::ST_START:
                    if (st_ff.tx_ph == `ASP_PH_BIT_END)
                    begin
                        nxt_st.tx_ph = 5'h00;
                        nxt_st.tx_bit = 3'h0;
                        nxt_st.tx_space = ~st_ff.tx_sh[0];
                        nxt_st.tx_st = asp_pkg::ST_DATA;
                    end
                asp_pkg::ST_DATA:
                    if (st_ff.tx_ph == `ASP_PH_BIT_END)
                    begin
                        nxt_st.tx_ph = 5'h00;
                        nxt_st.tx_sh = st_ff.tx_sh >> 1;
                        nxt_st.tx_bit = st_ff.tx_bit + 3'h1;
                        nxt_st.tx_space = ~st_ff.tx_sh[1];
                        if (st_ff.tx_bit == nbits)
                        begin
                            nxt_st.tx_space = st_ff.line_control[`ASP_LCR_PAR_ON] ? ~st_ff.tx_par : 1'b0;
                            nxt_st.tx_st = st_ff.line_control[`ASP_LCR_PAR_ON] ? asp_pkg::ST_PAR : asp_pkg::ST_STOP;
                        end
                    end
                asp_pkg::ST_PAR:
                    if (st_ff.tx_ph == `ASP_PH_BIT_END)
                    begin
                        nxt_st.tx_ph = 5'h00;
                        nxt_st.tx_space = 1'b0;
                        nxt_st.tx_st = asp_pkg::ST_STOP;
                    end
                asp_pkg::ST_STOP:
                    if (st_ff.tx_ph == stop_end)
                        nxt_st.tx_st = asp_pkg::ST_IDLE;
                default:
                    nxt_st.tx_st = asp_pkg::ST_IDLE;
            endcase
        end

        // receiver: a low line starts a frame, each bit sampled mid-cell
        if (tick)
        begin
            nxt_st.rx_ph = st_ff.rx_ph + 5'h01;
            case (st_ff.rx_st)
                asp_pkg::ST_IDLE:
                begin
                    nxt_st.rx_ph = 5'h00;
                    if (rx_line)
                        nxt_st.rx_st = asp_pkg::ST_START;
                end
                asp_pkg::ST_START:
                    // a start shorter than half a bit is a glitch
                    if (st_ff.rx_ph == `ASP_PH_MID && !rx_line)
                        nxt_st.rx_st = asp_pkg::ST_IDLE;
                    else if (st_ff.rx_ph == `ASP_PH_BIT_END)
                    begin
                        nxt_st.rx_ph = 5'h00;
                        nxt_st.rx_bit = 3'h0;
                        nxt_st.rx_st = asp_pkg::ST_DATA;
                    end
                asp_pkg::ST_DATA:
                    if (st_ff.rx_ph == `ASP_PH_MID)
                        nxt_st.rx_sh = {~rx_line, st_ff.rx_sh[7:1]};
                    else if (st_ff.rx_ph == `ASP_PH_BIT_END)
                    begin
                        nxt_st.rx_ph = 5'h00;
                        nxt_st.rx_bit = st_ff.rx_bit + 3'h1;
                        if (st_ff.rx_bit == nbits)
                            nxt_st.rx_st = st_ff.line_control[`ASP_LCR_PAR_ON] ? asp_pkg::ST_PAR : asp_pkg::ST_STOP;
                    end
                asp_pkg::ST_PAR:
                    if (st_ff.rx_ph == `ASP_PH_MID)
                        nxt_st.rx_par = ~rx_line;
                    else if (st_ff.rx_ph == `ASP_PH_BIT_END)
                    begin
                        nxt_st.rx_ph = 5'h00;
                        nxt_st.rx_st = asp_pkg::ST_STOP;
                    end
                asp_pkg::ST_STOP:
                    // ends mid-stop so the next start edge is not missed
                    if (st_ff.rx_ph == `ASP_PH_MID)
                        nxt_st.rx_st = asp_pkg::ST_IDLE;
                default:
                    nxt_st.rx_st = asp_pkg::ST_IDLE;
            endcase
        end

        // character complete: status set wins over a same-cycle read clear
        if (rx_done)
        begin
            nxt_st.receive_buffer = rx_data;
            nxt_st.dr = 1'b1;
            nxt_st.oe = st_ff.oe | (st_ff.dr && !(rd_en && addr == `ASP_OFS_DATA && !div_acc));
            nxt_st.fe = st_ff.fe | rx_line;
            nxt_st.pe = st_ff.pe | (st_ff.line_control[`ASP_LCR_PAR_ON] && (st_ff.rx_par != par_bit(rx_data, nbits, st_ff.line_control)));
            // parity cell counts only when parity is on; rx_par is stale otherwise
            nxt_st.bi = st_ff.bi | (rx_line && rx_data == 8'h00 && !(st_ff.line_control[`ASP_LCR_PAR_ON] && st_ff.rx_par));
        end
    end

    // ------------------------------------------------------------
    // registers and outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            st_ff <= RST_ST;
        else
            st_ff <= nxt_st;
    end

    assign rdata = st_ff.rdata;
    assign irq = !interrupt_identification[0];
    // break and loopback hold the line; loopback parks it at mark
    assign sout = loop | (!st_ff.tx_space && !st_ff.line_control[`ASP_LCR_BREAK]);
    assign dtr_n = ~st_ff.modem_control[0] | loop;
    assign rts_n = ~st_ff.modem_control[1] | loop;
    assign out1_n = ~st_ff.modem_control[2] | loop;
    assign out2_n = ~st_ff.modem_control[3] | loop;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    a_iir_upper: assert property (rd_en && addr == `ASP_OFS_IID |=> rdata[7:3] == 5'h00 && rdata[0] == !$past(irq))
        else $error("identification upper bits or pending bit wrong");
    a_lsr_top: assert property (rd_en && addr == `ASP_OFS_LSTAT |=> !rdata[7] && (rdata[6] -> rdata[5]))
        else $error("line status bit 7 or empty flags wrong");
    a_break_line: assert property (st_ff.line_control[`ASP_LCR_BREAK] && !loop |-> !sout)
        else $error("break not forcing line low");
    a_start_low: assert property ($rose(st_ff.tx_st == asp_pkg::ST_START) |-> !sout || loop || st_ff.line_control[6])
        else $error("start bit not low");
    a_stop_high: assert property (st_ff.tx_st == asp_pkg::ST_STOP |-> !st_ff.tx_space)
        else $error("stop bit not high");
    a_tick_gap: assert property (tick && st_ff.div > 16'h0001 |=> !tick)
        else $error("baud tick too frequent");
    a_thr_load: assert property (wr_en && addr == `ASP_OFS_DATA && !div_acc |=> st_ff.thr_full && !st_ff.tx_holding_empty_irq)
        else $error("holding register not loaded");
    a_ier_read: assert property (rd_en && addr == `ASP_OFS_IEN && !div_acc |=> rdata[7:4] == 4'h0)
        else $error("enable upper bits not zero");
    a_dr_clear: assert property (rd_en && addr == `ASP_OFS_DATA && !div_acc && !rx_done |=> !st_ff.dr)
        else $error("data ready not cleared by read");
    a_rls_first: assert property (pend[3] |-> interrupt_identification[2:1] == `ASP_ID_LINE)
        else $error("line status not highest priority");

endmodule // asp_serial_port

// file: test/asp_line_model.sv
// line-side partner: serial sender into sin, frame sampler on sout, modem inputs
// assumes divisor 1, so one bit cell is sixteen core clocks
`timescale 1ns/1ps
module asp_line_model
(
    input wire logic clk,
    input wire logic sout,
    output logic sin,
    output logic cts_n,
    output logic dsr_n,
    output logic ri_n,
    output logic dcd_n
);
    logic [11:0] cap;
    int cap_cnt;

    // ----------
    // sampler
    // ----------
    // mid-cell samples of twelve cells after each start edge
    initial
    begin
        cap_cnt = 0;
        forever
        begin
            @(negedge sout);
            repeat (8) @(posedge clk);
            for (int i = 0; i < 12; i++)
            begin
                cap[i] = sout;
                repeat (16) @(posedge clk);
            end
            cap_cnt++;
        end
    end

    // ----------
    // sender
    // ----------
    // idle lines sit high; modem inputs are active low
    initial
    begin
        sin = 1'b1;
        {dcd_n, ri_n, dsr_n, cts_n} = 4'hf;
    end

    // cells go out first to last; a short last cell stops a low stop bit posing as a new start
    task automatic send(input logic [11:0] bits, input int n, input int last);
        @(negedge clk);
        for (int i = 0; i < n; i++)
        begin
            sin = bits[i];
            repeat ((i == n - 1) ? last : 16) @(negedge clk);
        end
        sin = 1'b1;
    endtask

    task automatic modem(input logic [3:0] lv);
        @(negedge clk);
        {dcd_n, ri_n, dsr_n, cts_n} = lv;
    endtask
endmodule // asp_line_model

// file: test/tb_top.sv
// testbench of the serial port unit: register tasks, frame, status and modem scenarios
// assumes asp_line_model on the line side and divisor 1 (one bit = 16 clocks)
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [2:0] addr = 3'h0;
    logic rd_en = 1'b0;
    logic wr_en = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic irq, sin, sout, cts_n, dsr_n, ri_n, dcd_n, dtr_n, rts_n, out1_n, out2_n;
    int errors = 0;
    int comparisons = 0;

    always #12.5 clk = ~clk;

    asp_serial_port asp_serial_port_inst (.clk(clk), .arst_n(arst_n), .addr(addr), .rd_en(rd_en),
        .wr_en(wr_en), .wdata(wdata), .rdata(rdata), .irq(irq), .sin(sin), .sout(sout), .cts_n(cts_n),
        .dsr_n(dsr_n), .ri_n(ri_n), .dcd_n(dcd_n), .dtr_n(dtr_n), .rts_n(rts_n), .out1_n(out1_n),
        .out2_n(out2_n));
    asp_line_model line_inst (.clk(clk), .sout(sout), .sin(sin), .cts_n(cts_n), .dsr_n(dsr_n),
        .ri_n(ri_n), .dcd_n(dcd_n));

    // ----------
    // register port and compare
    // ----------
    // one-cycle strobes launched at the falling edge, so the rising edge sees them settled
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr_en = 1'b1;
        @(negedge clk);
        wr_en = 1'b0;
    endtask

    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // read data is registered, so it is taken half a cycle after the strobe edge
    task automatic rchk(input logic [2:0] a, input logic [7:0] m, input logic [7:0] exp);
        @(negedge clk);
        addr = a;
        rd_en = 1'b1;
        @(negedge clk);
        rd_en = 1'b0;
        chk(rdata & m, exp);
    endtask

    // bounded wait for the sampler to finish a frame
    task automatic wait_cap(input int c);
        for (int w = 0; w < 1000 && line_inst.cap_cnt == c; w++)
            @(posedge clk);
        @(negedge clk);
    endtask

    // ----------
    // scenarios
    // ----------
    task automatic t_regs();
        rchk(3'h2, 8'hff, 8'h01);
        rchk(3'h5, 8'hff, 8'h60);
        wr(3'h1, 8'h0f);
        rchk(3'h1, 8'hff, 8'h0f);
        wr(3'h7, 8'h5a);
        wr(3'h2, 8'hff);
        rchk(3'h7, 8'hff, 8'h5a);
        rchk(3'h2, 8'hff, 8'h01);
        // small high byte keeps the baud counter reload short
        wr(3'h3, 8'h80);
        wr(3'h0, 8'h02);
        wr(3'h1, 8'h01);
        rchk(3'h0, 8'hff, 8'h02);
        rchk(3'h1, 8'hff, 8'h01);
        wr(3'h1, 8'h00);
        wr(3'h0, 8'h01);
        wr(3'h3, 8'h03);
        rchk(3'h1, 8'hff, 8'h0f);
        rchk(3'h3, 8'hff, 8'h03);
        wr(3'h1, 8'h00);
    endtask

    // every length, each parity mode; the stop cells and idle must read high
    task automatic t_tx();
        logic [7:0] lc [4] = '{8'h03, 8'h1a, 8'h0c, 8'h39};
        logic [7:0] dv [4] = '{8'ha5, 8'h35, 8'h16, 8'h2e};
        logic [11:0] ex;
        logic p;
        int n, c;
        for (int k = 0; k < 4; k++)
        begin
            n = 5 + lc[k][1:0];
            ex = 12'hffe;
            for (int i = 0; i < n; i++)
                ex[1 + i] = dv[k][i];
            p = ^(dv[k] & (8'hff >> (8 - n)));
            if (lc[k][5])
                p = ~lc[k][4];
            else if (!lc[k][4])
                p = ~p;
            if (lc[k][3])
                ex[n + 1] = p;
            wr(3'h3, lc[k]);
            c = line_inst.cap_cnt;
            wr(3'h0, dv[k]);
            rchk(3'h5, 8'h40, 8'h00);
            wait_cap(c);
            chk(line_inst.cap, ex);
            rchk(3'h5, 8'hff, 8'h60);
        end
        wr(3'h1, 8'h02);
        c = line_inst.cap_cnt;
        wr(3'h0, 8'h41);
        repeat (4) @(negedge clk);
        chk(irq, 1'b1);
        rchk(3'h2, 8'hff, 8'h02);
        rchk(3'h2, 8'hff, 8'h01);
        wait_cap(c);
        wr(3'h1, 8'h00);
    endtask

    task automatic t_rx();
        wr(3'h3, 8'h03);
        line_inst.send({2'b11, 8'hc3, 1'b0}, 10, 16);
        repeat (20) @(negedge clk);
        rchk(3'h5, 8'hff, 8'h61);
        rchk(3'h0, 8'hff, 8'hc3);
        rchk(3'h5, 8'h01, 8'h00);
        line_inst.send({2'b11, 8'h11, 1'b0}, 10, 16);
        line_inst.send({2'b11, 8'h22, 1'b0}, 10, 16);
        repeat (20) @(negedge clk);
        rchk(3'h5, 8'h03, 8'h03);
        rchk(3'h5, 8'h02, 8'h00);
        rchk(3'h0, 8'hff, 8'h22);
        // seven bits, odd parity, wrong parity cell sent
        wr(3'h3, 8'h0a);
        line_inst.send({2'b11, 7'h15, 1'b0}, 10, 16);
        repeat (20) @(negedge clk);
        rchk(3'h5, 8'h04, 8'h04);
        rchk(3'h5, 8'h04, 8'h00);
        rchk(3'h0, 8'h7f, 8'h15);
        // low stop bit with line status and data sources enabled
        wr(3'h3, 8'h03);
        wr(3'h1, 8'h05);
        line_inst.send({2'b00, 8'h01, 1'b0}, 10, 12);
        repeat (30) @(negedge clk);
        chk(irq, 1'b1);
        rchk(3'h2, 8'hff, 8'h06);
        rchk(3'h5, 8'h18, 8'h08);
        rchk(3'h2, 8'hff, 8'h04);
        rchk(3'h0, 8'hff, 8'h01);
        rchk(3'h2, 8'hff, 8'h01);
        chk(irq, 1'b0);
        // all-low frame after a parity frame: break must not hang on the old parity cell
        line_inst.send(12'h000, 10, 12);
        repeat (30) @(negedge clk);
        rchk(3'h5, 8'h18, 8'h18);
        rchk(3'h0, 8'hff, 8'h00);
        wr(3'h1, 8'h00);
    endtask

    task automatic t_modem();
        rchk(3'h6, 8'hff, 8'h00);
        line_inst.modem(4'h0);
        repeat (4) @(negedge clk);
        rchk(3'h6, 8'hff, 8'hfb);
        rchk(3'h6, 8'hff, 8'hf0);
        line_inst.modem(4'h4);
        repeat (4) @(negedge clk);
        rchk(3'h6, 8'hff, 8'hb4);
        wr(3'h4, 8'h05);
        chk({dtr_n, rts_n, out1_n, out2_n}, 4'h5);
        rchk(3'h4, 8'hff, 8'h05);
        wr(3'h4, 8'h13);
        repeat (4) @(negedge clk);
        rchk(3'h6, 8'hf0, 8'h30);
        chk({dtr_n, rts_n, out1_n, out2_n, sout}, 5'h1f);
        wr(3'h4, 8'h00);
        wr(3'h3, 8'h43);
        chk(sout, 1'b0);
        wr(3'h3, 8'h03);
        chk(sout, 1'b1);
    endtask

    // ----------
    // run control
    // ----------
    task automatic conclude();
        $display("comparisons=%0d errors=%0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        repeat (16) @(posedge clk);
        @(negedge clk);
        arst_n = 1'b1;
        chk({rdata, irq, sout}, 10'h001);
        chk({dtr_n, rts_n, out1_n, out2_n}, 4'hf);
        t_regs();
        t_tx();
        t_rx();
        t_modem();
        conclude();
    end

    // the scenarios need under 5000 cycles; a hang is cut off well beyond that
    initial
    begin
        repeat (20000) @(posedge clk);
        errors++;
        conclude();
    end
endmodule // tb_top
